//--- core/see_host.sv
// Bus master that issues current, random and sequential reads
`timescale 1ns/1ps
module see_host
   import see_pkg::*;
#(
   parameter int QUARTER_CYC = see_pkg::SEE_QUARTER_CYC
)
(
   see_link_if.master link,
   input wire logic clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_random,
   input wire logic [see_pkg::SEE_ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_count,
   input wire logic [1:0] cmd_chip_sel,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic busy,
   output logic nack_error
);
   import see_pkg::*;

   if (QUARTER_CYC < 3 || QUARTER_CYC >= (1 << SEE_QCNT_W))
   begin : g_check
      $error("QUARTER_CYC out of range");
   end

   localparam logic [SEE_QCNT_W-1:0] QLAST = SEE_QCNT_W'(QUARTER_CYC - 1);

   typedef struct packed {
      see_host_state_t st;
      logic [SEE_QCNT_W-1:0] qcnt;
      logic [1:0] quart;
      logic [2:0] bitn;
      logic [7:0] shreg;
      see_stage_t stage;
      logic [SEE_ADDR_W-1:0] addr;
      logic [7:0] left;
      logic [1:0] cs;
      logic scl;
      logic sda_oe;
      logic sda_s1;
      logic sda_s2;
      logic ack_bit;
      logic err;
      logic [SEE_RX_FIFO_DEPTH-1:0][7:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } see_host_regs_t;

   see_host_regs_t r_reg;
   see_host_regs_t r_next;
   logic tick;
   logic sym_end;
   logic sample;
   logic stall;
   logic pop;

   function automatic logic [7:0] ctrl_byte(input logic [1:0] cs, input logic blk,
                                           input logic dir);
      return {SEE_CTRL_CODE, cs, blk, dir};
   endfunction

   always_comb
   begin
      pop = (r_reg.cnt != 2'h0) && rx_ready;
      // Hold the clock low before a new byte while the buffer has no room
      stall = (r_reg.st == SEE_H_RX) && (r_reg.bitn == 3'h0) && (r_reg.quart == 2'h0)
         && (r_reg.cnt == 2'(SEE_RX_FIFO_DEPTH)) && !pop;
      tick = (r_reg.qcnt == QLAST) && !stall;
      sym_end = tick && (r_reg.quart == 2'h3);
      sample = (r_reg.quart == 2'h3) && (r_reg.qcnt == '0);
   end

   always_comb
   begin
      r_next = r_reg;
      r_next.sda_s1 = link.sda;
      r_next.sda_s2 = r_reg.sda_s1;
      if (pop)
      begin
         r_next.rp = ~r_reg.rp;
         r_next.cnt = r_reg.cnt - 2'h1;
      end
      if (r_reg.st == SEE_H_IDLE)
      begin
         r_next.scl = 1'h1;
         r_next.sda_oe = 1'h0;
         if (cmd_valid)
         begin
            r_next.st = SEE_H_START;
            r_next.qcnt = '0;
            r_next.quart = 2'h0;
            r_next.addr = cmd_addr;
            r_next.cs = cmd_chip_sel;
            r_next.left = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
            r_next.stage = cmd_random ? SEE_STG_CTRL_WR : SEE_STG_CTRL_RD;
            r_next.err = 1'h0;
         end
      end
      else
      begin
         if (!stall)
         begin
            r_next.qcnt = tick ? '0 : r_reg.qcnt + 1'h1;
         end
         if (tick)
         begin
            r_next.quart = r_reg.quart + 2'h1;
            r_next.scl = r_next.quart[1];
            // Data bits move in the second low quarter, clear of the falling edge; start and stop move it in the high phase
            if (r_reg.quart == 2'h0)
            begin
               case (r_reg.st)
                  SEE_H_START: r_next.sda_oe = 1'h0;
                  SEE_H_TX: r_next.sda_oe = ~r_reg.shreg[7];
                  SEE_H_TACK: r_next.sda_oe = (r_reg.left != 8'h01);
                  SEE_H_STOP: r_next.sda_oe = 1'h1;
                  default: r_next.sda_oe = 1'h0;
               endcase
            end
            else if (r_reg.quart == 2'h2)
            begin
               if (r_reg.st == SEE_H_START)
               begin
                  r_next.sda_oe = 1'h1;
               end
               else if (r_reg.st == SEE_H_STOP)
               begin
                  r_next.sda_oe = 1'h0;
               end
            end
         end
         if (sample)
         begin
            r_next.ack_bit = r_reg.sda_s2;
            if (r_reg.st == SEE_H_RX)
            begin
               r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_s2};
            end
         end
         if (sym_end)
         begin
            case (r_reg.st)
               SEE_H_START:
               begin
                  r_next.shreg = ctrl_byte(r_reg.cs, r_reg.addr[8],
                     (r_reg.stage == SEE_STG_CTRL_RD) ? SEE_DIR_READ : SEE_DIR_WRITE);
                  r_next.bitn = 3'h0;
                  r_next.st = SEE_H_TX;
               end
               SEE_H_TX:
               begin
                  r_next.bitn = r_reg.bitn + 3'h1;
                  r_next.shreg = {r_reg.shreg[6:0], 1'h0};
                  if (r_reg.bitn == SEE_LAST_BIT)
                  begin
                     r_next.st = SEE_H_RACK;
                  end
               end
               SEE_H_RACK:
               begin
                  r_next.bitn = 3'h0;
                  if (r_reg.ack_bit)
                  begin
                     r_next.err = 1'h1;
                     r_next.st = SEE_H_STOP;
                  end
                  else if (r_reg.stage == SEE_STG_CTRL_WR)
                  begin
                     r_next.stage = SEE_STG_ADDR;
                     r_next.shreg = r_reg.addr[7:0];
                     r_next.st = SEE_H_TX;
                  end
                  else if (r_reg.stage == SEE_STG_ADDR)
                  begin
                     r_next.stage = SEE_STG_CTRL_RD;
                     r_next.st = SEE_H_START;
                  end
                  else
                  begin
                     r_next.st = SEE_H_RX;
                  end
               end
               SEE_H_RX:
               begin
                  r_next.bitn = r_reg.bitn + 3'h1;
                  if (r_reg.bitn == SEE_LAST_BIT)
                  begin
                     r_next.mem[r_reg.wp] = r_reg.shreg;
                     r_next.wp = ~r_reg.wp;
                     r_next.cnt = r_next.cnt + 2'h1;
                     r_next.st = SEE_H_TACK;
                  end
               end
               SEE_H_TACK:
               begin
                  if (r_reg.left != 8'h01)
                  begin
                     r_next.left = r_reg.left - 8'h01;
                     r_next.bitn = 3'h0;
                     r_next.st = SEE_H_RX;
                  end
                  else
                  begin
                     r_next.st = SEE_H_STOP;
                  end
               end
               default:
               begin
                  r_next.st = SEE_H_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r_reg <= '{st: SEE_H_IDLE, scl: 1'h1, sda_s1: 1'h1, sda_s2: 1'h1,
                    ack_bit: 1'h1, stage: SEE_STG_CTRL_RD, default: '0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign link.scl = r_reg.scl;
   assign link.m_sda_o = 1'h0;
   assign link.m_sda_oe = r_reg.sda_oe;
   assign cmd_ready = (r_reg.st == SEE_H_IDLE);
   assign busy = (r_reg.st != SEE_H_IDLE);
   assign nack_error = r_reg.err;
   assign rx_valid = (r_reg.cnt != 2'h0);
   assign rx_data = r_reg.mem[r_reg.rp];

endmodule // see_host

//--- include/see_pkg.sv
// Shared constants and types for the serial EEPROM read path and its bus master
package see_pkg;

   // Control byte layout
   localparam logic [3:0] SEE_CTRL_CODE = 4'ha;
   localparam int SEE_CB_DIR = 0;
   localparam int SEE_CB_BLK = 1;
   localparam int SEE_CB_CSL = 2;
   localparam int SEE_CB_CSH = 3;
   localparam logic SEE_DIR_READ = 1'h1;
   localparam logic SEE_DIR_WRITE = 1'h0;

   // Array addressing
   localparam int SEE_ADDR_W = 9;
   localparam logic [8:0] SEE_ADDR_TOP = 9'h1ff;
   localparam logic [8:0] SEE_ADDR_BOTTOM = 9'h000;
   localparam logic [8:0] SEE_PTR_RESET = 9'h000;
   localparam logic [2:0] SEE_LAST_BIT = 3'h7;

   // Host timing
   localparam int SEE_CLK_PERIOD_NS = 50;
   localparam int SEE_SCL_PERIOD_NS = 10000;
   localparam int SEE_QUARTER_CYC = SEE_SCL_PERIOD_NS / (4 * SEE_CLK_PERIOD_NS);
   localparam int SEE_QCNT_W = 16;
   localparam int SEE_RX_FIFO_DEPTH = 2;

   typedef enum logic [8:0] {
      SEE_D_IDLE = 9'h001,
      SEE_D_CTRL = 9'h002,
      SEE_D_CACK = 9'h004,
      SEE_D_ADDR = 9'h008,
      SEE_D_AACK = 9'h010,
      SEE_D_WAIT = 9'h020,
      SEE_D_TX = 9'h040,
      SEE_D_TXACK = 9'h080,
      SEE_D_SPARE = 9'h100
   } see_dev_state_t;

   typedef enum logic [6:0] {
      SEE_H_IDLE = 7'h01,
      SEE_H_START = 7'h02,
      SEE_H_TX = 7'h04,
      SEE_H_RACK = 7'h08,
      SEE_H_RX = 7'h10,
      SEE_H_TACK = 7'h20,
      SEE_H_STOP = 7'h40
   } see_host_state_t;

   // Which byte the host sends: a control byte after a start, or the address after the write control byte
   typedef enum logic [1:0] {
      SEE_STG_CTRL_WR = 2'h0,
      SEE_STG_ADDR = 2'h1,
      SEE_STG_CTRL_RD = 2'h2
   } see_stage_t;

endpackage

//--- include/see_link_if.sv
// Two-wire link between the bus master and the EEPROM read path
`timescale 1ns/1ps
interface see_link_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;

   // Open-drain wire with pull-up: low if any enabled driver drives low
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport master (
      output scl,
      output m_sda_o,
      output m_sda_oe,
      input sda
   );

   modport slave (
      input scl,
      output s_sda_o,
      output s_sda_oe,
      input sda
   );
endinterface

//--- core/see_dev.sv
// EEPROM read path: control byte decode, address pointer and byte shifter
`timescale 1ns/1ps
module see_dev
   import see_pkg::*;
(
   see_link_if.slave link,
   input wire logic resetn,
   input wire logic chip_select_high_pin,
   input wire logic chip_select_low_pin,
   input wire logic prog_busy,
   output logic [see_pkg::SEE_ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic read_active
);
   import see_pkg::*;

   typedef struct packed {
      see_dev_state_t st;
      logic [2:0] bitn;
      logic [7:0] shreg;
      logic [SEE_ADDR_W-1:0] ptr;
      logic sda_oe;
      logic block_select_bit;
      logic dir;
      logic [1:0] cs_s1;
      logic [1:0] cs_s2;
      logic busy_s1;
      logic busy_s2;
   } see_dev_regs_t;

   localparam see_dev_regs_t SEE_DEV_RESET = '{
      st: SEE_D_IDLE,
      bitn: 3'h0,
      shreg: 8'h00,
      ptr: SEE_PTR_RESET,
      sda_oe: 1'h0,
      block_select_bit: 1'h0,
      dir: SEE_DIR_WRITE,
      cs_s1: 2'h0,
      cs_s2: 2'h0,
      busy_s1: 1'h0,
      busy_s2: 1'h0
   };

   see_dev_regs_t r_reg;
   see_dev_regs_t r_next;
   logic sda_hi_reg;

   logic [7:0] rx_byte;
   logic ev_start;
   logic ev_stop;
   logic byte_done;
   logic ctrl_match;

   // Next address with explicit roll-over at the top of the array
   function automatic logic [SEE_ADDR_W-1:0] next_addr(input logic [SEE_ADDR_W-1:0] a);
      if (a == SEE_ADDR_TOP)
      begin
         return SEE_ADDR_BOTTOM;
      end
      return a + 9'h001;
   endfunction

   // Open-drain: enable means pull low, so a zero bit enables the driver
   function automatic logic drive_low(input logic b);
      return ~b;
   endfunction

   // Data is sampled while the clock is high; comparing it with the level at the
   // falling edge reveals a start or stop that happened during that high phase.
   // A stop is therefore seen at the next falling edge of the clock; the master
   // supplies that edge as it leaves its stop state, before idle lets the clock rise again.
   always_ff @(posedge link.scl or negedge resetn)
   begin
      if (!resetn)
      begin
         sda_hi_reg <= 1'h1;
      end
      else
      begin
         sda_hi_reg <= link.sda;
      end
   end

   always_comb
   begin
      ev_start = sda_hi_reg & ~link.sda;
      ev_stop = ~sda_hi_reg & link.sda;
      rx_byte = {r_reg.shreg[6:0], sda_hi_reg};
      byte_done = (r_reg.bitn == SEE_LAST_BIT);
      ctrl_match = (rx_byte[7:4] == SEE_CTRL_CODE) &&
         (rx_byte[SEE_CB_CSH] == r_reg.cs_s2[1]) &&
         (rx_byte[SEE_CB_CSL] == r_reg.cs_s2[0]);
   end

   always_comb
   begin
      r_next = r_reg;
      r_next.cs_s1 = {chip_select_high_pin, chip_select_low_pin};
      r_next.cs_s2 = r_reg.cs_s1;
      r_next.busy_s1 = prog_busy;
      r_next.busy_s2 = r_reg.busy_s1;
      if (ev_start)
      begin
         // Also covers the repeated start that abandons a write
         r_next.st = SEE_D_CTRL;
         r_next.bitn = 3'h0;
         r_next.sda_oe = 1'h0;
      end
      else if (ev_stop)
      begin
         r_next.st = SEE_D_IDLE;
         r_next.sda_oe = 1'h0;
      end
      else
      begin
         case (r_reg.st)
            SEE_D_CTRL:
            begin
               r_next.shreg = rx_byte;
               r_next.bitn = r_reg.bitn + 3'h1;
               if (byte_done)
               begin
                  if (ctrl_match && !r_reg.busy_s2)
                  begin
                     r_next.sda_oe = 1'h1;
                     r_next.block_select_bit = rx_byte[SEE_CB_BLK];
                     r_next.dir = rx_byte[SEE_CB_DIR];
                     r_next.st = SEE_D_CACK;
                  end
                  else
                  begin
                     r_next.st = SEE_D_IDLE;
                  end
               end
            end
            SEE_D_CACK:
            begin
               r_next.bitn = 3'h0;
               if (r_reg.dir == SEE_DIR_READ)
               begin
                  // Current-address read starts at the stored pointer
                  r_next.shreg = mem_rdata;
                  r_next.sda_oe = drive_low(mem_rdata[7]);
                  r_next.st = SEE_D_TX;
               end
               else
               begin
                  r_next.sda_oe = 1'h0;
                  r_next.st = SEE_D_ADDR;
               end
            end
            SEE_D_ADDR:
            begin
               r_next.shreg = rx_byte;
               r_next.bitn = r_reg.bitn + 3'h1;
               if (byte_done)
               begin
                  if (r_reg.busy_s2)
                  begin
                     r_next.st = SEE_D_IDLE;
                  end
                  else
                  begin
                     r_next.ptr = {r_reg.block_select_bit, rx_byte};
                     r_next.sda_oe = 1'h1;
                     r_next.st = SEE_D_AACK;
                  end
               end
            end
            SEE_D_AACK:
            begin
               // Write data is not stored; only a start or stop moves on
               r_next.sda_oe = 1'h0;
               r_next.st = SEE_D_WAIT;
            end
            SEE_D_TX:
            begin
               if (byte_done)
               begin
                  r_next.sda_oe = 1'h0;
                  r_next.ptr = next_addr(r_reg.ptr);
                  r_next.st = SEE_D_TXACK;
               end
               else
               begin
                  r_next.bitn = r_reg.bitn + 3'h1;
                  r_next.shreg = {r_reg.shreg[6:0], 1'h0};
                  r_next.sda_oe = drive_low(r_reg.shreg[6]);
               end
            end
            SEE_D_TXACK:
            begin
               if (!sda_hi_reg)
               begin
                  r_next.shreg = mem_rdata;
                  r_next.sda_oe = drive_low(mem_rdata[7]);
                  r_next.bitn = 3'h0;
                  r_next.st = SEE_D_TX;
               end
               else
               begin
                  // Line stays released so the master can make its stop
                  r_next.sda_oe = 1'h0;
                  r_next.st = SEE_D_IDLE;
               end
            end
            SEE_D_IDLE, SEE_D_WAIT:
            begin
               r_next.sda_oe = 1'h0;
            end
            default:
            begin
               r_next.st = SEE_D_IDLE;
               r_next.sda_oe = 1'h0;
            end
         endcase
      end
   end

   // Outputs change on the falling edge so data only moves while the clock is low
   always_ff @(negedge link.scl or negedge resetn)
   begin
      if (!resetn)
      begin
         r_reg <= SEE_DEV_RESET;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign link.s_sda_o = 1'h0;
   assign link.s_sda_oe = r_reg.sda_oe;
   assign mem_addr = r_reg.ptr;
   assign read_active = (r_reg.st == SEE_D_TX) || (r_reg.st == SEE_D_TXACK);

endmodule // see_dev

//--- verif/see_link_asserts.sv
// Wire-level checker for the two-wire link between bus master and read path
`timescale 1ns/1ps
module see_link_asserts
   import see_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic sda
);
   import see_pkg::*;

   logic scl_reg;
   logic sda_reg;
   logic ctrl_dir_reg;
   logic nack_reg;
   logic [3:0] bit_cnt_reg;
   logic [1:0] byte_no_reg;
   logic [7:0] shift_reg;
   logic start_seen;

   // Start: data falls while the clock stays high over two samples
   assign start_seen = scl & scl_reg & sda_reg & ~sda;

   // Bit counter follows the wire only; bits seen before the first start are junk
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         ctrl_dir_reg <= 1'b0;
         nack_reg <= 1'b0;
         bit_cnt_reg <= 4'h0;
         byte_no_reg <= 2'h0;
         shift_reg <= 8'h00;
      end
      else
      begin
         scl_reg <= scl;
         sda_reg <= sda;
         if (start_seen)
         begin
            bit_cnt_reg <= 4'h0;
            byte_no_reg <= 2'h0;
            nack_reg <= 1'b0;
         end
         else if (scl && !scl_reg)
         begin
            if (bit_cnt_reg == 4'h8)
            begin
               bit_cnt_reg <= 4'h0;
               if (byte_no_reg != 2'h3)
               begin
                  byte_no_reg <= byte_no_reg + 2'h1;
               end
               if (byte_no_reg == 2'h0)
               begin
                  ctrl_dir_reg <= shift_reg[0];
               end
               if (ctrl_dir_reg && byte_no_reg != 2'h0 && sda)
               begin
                  nack_reg <= 1'b1;
               end
            end
            else
            begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               shift_reg <= {shift_reg[6:0], sda};
            end
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_ack_slot;
      $rose(scl) && bit_cnt_reg == 4'h8;
   endsequence

   sequence s_data_slot;
      $rose(scl) && bit_cnt_reg != 4'h8;
   endsequence

   a_dev_moves_fall: assert property ($changed(s_sda_oe) |-> $fell(scl))
      else $error("device data moved outside a clock falling edge");
   a_start_clean: assert property (start_seen |-> m_sda_oe && !s_sda_oe)
      else $error("start not made by the master alone");
   a_ctrl_code_ack: assert property ((s_ack_slot ##0 (s_sda_oe && byte_no_reg == 2'h0))
      |-> shift_reg[7:4] == SEE_CTRL_CODE)
      else $error("control byte acknowledged without the device code");
   a_ack_addr_only: assert property ((s_ack_slot ##0 s_sda_oe)
      |-> byte_no_reg == 2'h0 || (byte_no_reg == 2'h1 && !ctrl_dir_reg))
      else $error("device acknowledged a byte other than control or address");
   a_data_on_read: assert property ((s_data_slot ##0 s_sda_oe)
      |-> ctrl_dir_reg && byte_no_reg != 2'h0)
      else $error("device drove data outside a read transfer");
   a_nack_release: assert property (nack_reg |-> !s_sda_oe)
      else $error("device drove data after the final no-ack");
   a_free_ack_slot: assert property ((s_ack_slot ##0 (ctrl_dir_reg && byte_no_reg != 2'h0))
      |-> !s_sda_oe)
      else $error("device drove the master acknowledge slot");
   a_open_drain: assert property (!s_sda_o && !m_sda_o)
      else $error("data line driven high");
endmodule // see_link_asserts

//--- verif/serial_eeprom_read_path_test.sv
// Self-checking bench: bus master and read path joined over the link
`timescale 1ns/1ps
module serial_eeprom_read_path_test;
   import see_pkg::*;

   logic clk = 1'b0;
   logic resetn;
   logic cmd_valid = 1'b0;
   logic cmd_random = 1'b0;
   logic [8:0] cmd_addr = 9'h000;
   logic [7:0] cmd_count = 8'h00;
   logic [1:0] cmd_chip_sel = 2'h2;
   logic [1:0] pins = 2'h2;
   logic rx_ready = 1'b0;
   logic prog_busy = 1'b0;
   logic cmd_ready;
   logic rx_valid;
   logic [7:0] rx_data;
   logic busy;
   logic nack_error;
   logic [8:0] mem_addr;
   logic [7:0] mem_rdata;
   logic read_active;
   logic [7:0] mem [512];
   logic [31:0] seed = 32'hcfb044a0;
   logic [8:0] exp_ptr = 9'h000;
   logic [7:0] got_q [$];
   logic [31:0] r;
   int failures = 0;
   int tests_run = 0;
   logic act_seen = 1'b0;

   always #25 clk = ~clk;

   see_link_if see_link_if_i();
   see_host #(.QUARTER_CYC(3)) see_host_i (.link(see_link_if_i.master), .clk(clk),
      .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_random(cmd_random),
      .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_chip_sel(cmd_chip_sel),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .busy(busy),
      .nack_error(nack_error));
   see_dev see_dev_i (.link(see_link_if_i.slave), .resetn(resetn),
      .chip_select_high_pin(pins[1]), .chip_select_low_pin(pins[0]), .prog_busy(prog_busy),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .read_active(read_active));
   see_link_asserts see_link_asserts_i (.clk(clk), .resetn(resetn), .scl(see_link_if_i.scl),
      .m_sda_o(see_link_if_i.m_sda_o), .m_sda_oe(see_link_if_i.m_sda_oe),
      .s_sda_o(see_link_if_i.s_sda_o), .s_sda_oe(see_link_if_i.s_sda_oe),
      .sda(see_link_if_i.sda));

   assign mem_rdata = mem[mem_addr];

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Random stalls on the user side (ready low about one cycle in four) hold some bytes in the two-entry buffer
   always @(posedge clk) rx_ready <= (xs() & 32'h3) != 32'h0;

   always @(posedge clk)
   begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
      begin
         got_q.push_back(rx_data);
      end
      if (read_active === 1'b1)
      begin
         act_seen = 1'b1;
      end
   end

   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_addr(input string what, input logic [8:0] exp, input logic [8:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One command; ok low means the device is expected to stay silent
   task automatic run_cmd(input logic rnd, input logic [8:0] addr, input logic [7:0] cnt,
      input logic [1:0] cs, input logic ok);
      int n;
      int k;
      logic [8:0] a;
      got_q.delete();
      act_seen = 1'b0;
      a = rnd ? addr : exp_ptr;
      n = ok ? ((cnt == 8'h00) ? 1 : int'(cnt)) : 0;
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_random <= rnd;
      cmd_addr <= addr;
      cmd_count <= cnt;
      cmd_chip_sel <= cs;
      @(posedge clk);
      cmd_valid <= 1'b0;
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while ((busy !== 1'b0 || rx_valid !== 1'b0) && k < 20000);
      if (k >= 20000)
      begin
         failures++;
         $display("BAD busy expected 0 seen %b", busy);
      end
      cmp_byte("nack_error", {7'h00, !ok}, {7'h00, nack_error});
      cmp_addr("byte count", 9'(n), 9'(got_q.size()));
      for (int i = 0; i < n && i < got_q.size(); i++)
      begin
         cmp_byte("rx_data", mem[9'(a + i)], got_q[i]);
      end
      if (ok)
      begin
         exp_ptr = 9'(a + n);
      end
      cmp_addr("mem_addr", exp_ptr, mem_addr);
      cmp_byte("read_active seen", {7'h00, ok}, {7'h00, act_seen});
      cmp_byte("read_active", 8'h00, {7'h00, read_active});
   endtask

   initial
   begin
      // Unknown to low is a falling edge, so the link-clocked end resets with no clock running
      resetn <= 1'b0;
      for (int i = 0; i < 512; i++)
      begin
         mem[i] = 8'(xs());
      end
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      run_cmd(1'b1, 9'h1fe, 8'h04, 2'h2, 1'b1);
      run_cmd(1'b0, 9'h000, 8'h01, 2'h2, 1'b1);
      run_cmd(1'b1, 9'h0ff, 8'h00, 2'h2, 1'b1);
      run_cmd(1'b0, 9'h000, 8'h03, 2'h2, 1'b1);
      run_cmd(1'b1, 9'h055, 8'h02, 2'h1, 1'b0);
      run_cmd(1'b0, 9'h055, 8'h02, 2'h0, 1'b0);
      @(posedge clk);
      prog_busy <= 1'b1;
      run_cmd(1'b1, 9'h123, 8'h01, 2'h2, 1'b0);
      @(posedge clk);
      prog_busy <= 1'b0;
      for (int j = 0; j < 8; j++)
      begin
         r = xs();
         @(posedge clk);
         pins <= r[21:20];
         run_cmd(r[31], r[8:0], {5'h00, r[14:12]}, r[21:20], 1'b1);
      end
      // Pointer must come back to the bottom after a reset in mid-run
      @(posedge clk);
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      exp_ptr = SEE_PTR_RESET;
      run_cmd(1'b0, 9'h000, 8'h02, pins, 1'b1);
      close_out;
   end

   // Whole sequence needs roughly 8000 cycles, at most about 12000
   initial
   begin
      repeat (80000) @(posedge clk);
      failures++;
      close_out;
   end
endmodule // serial_eeprom_read_path_test
